/* File: dfs_ctrl.sv */
/*
 * Synthesizer control core: three-wire serial loader, setting latches,
 * profile and fsk frequency word, nco, acquisition pump gating, slicer.
 * Assumes clk is the reference clock; serial pins, profile, tx data and
 * lock come from outside and are synchronised here.
 */
// Added by the designer: the plain strobed port and the address map.
// Notes on behaviour
// - 24-bit phase accumulator adds the frequency word every clock, wraps.
// - accumulator is an unsigned up-counting adder, a repeating ramp.
// - accumulator output addresses a sine table; sample goes to the dac.
// - profile words are 22 bits; top two frequency bits are zero.
// - profile pin low picks profile zero word, high picks profile one.
// - fsk acts only when the c-word modulation select bit 16 is zero.
// - deviation sits two bits up, so the offset is four times it.
// - fsk: tx data low uses the profile word, high adds deviation.
// - setting latches are static and survive standby untouched.
// - feedback prescaler ratio is either 256 or 512.
// - acquisition pump pulses only while unlocked, off once locked.
// - three-bit c-word gain field sets the acquisition pump factor.
// - learning mode integrates the input to update the threshold.
// - hold mode freezes the threshold and slices input to data out.
// - serial data shifts into 24 bits per serial clock rise, msb first.
// - load line rise moves the word to its addressed latch.
// - more than 24 bits before a load keeps only the last 24.
`timescale 1ns/1ps
module dfs_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  input wire logic profile_sel,
  input wire logic tx_mod,
  input wire logic pll_locked,
  input wire logic phase_slip,
  input wire logic signed [7:0] demod_sample,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic [9:0] dac_out,
  output logic [9:0] div_ratio,
  output logic [2:0] acq_gain,
  output logic acquisition_pump_out,
  output logic osc_enable,
  output logic test_mode,
  output logic signed [7:0] threshold_hold_cap,
  output logic rx_data
);
  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sclk_d_r;
  logic load_d_r;
  logic slip_d_r;
  logic sclk_s;
  logic sdat_s;
  logic load_s;
  logic prof_s;
  logic txm_s;
  logic lock_s;
  logic slip_s;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {lock_in_w(pll_locked), phase_slip, tx_mod, profile_sel,
                  ser_load, ser_data};
      sync2_r <= sync1_r;
    end
  end

  // identity helper keeps the pin list grouped in one vector
  function automatic logic lock_in_w(input logic v);
    return v;
  endfunction : lock_in_w

  assign sdat_s = sync2_r[0];
  assign load_s = sync2_r[1];
  assign prof_s = sync2_r[2];
  assign txm_s = sync2_r[3];
  assign slip_s = sync2_r[4];
  assign lock_s = sync2_r[5];

  // serial clock kept in its own pair so its edge is seen cleanly
  logic sclk1_r;
  logic sclk2_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk1_r <= 1'b0;
      sclk2_r <= 1'b0;
    end else begin
      sclk1_r <= ser_clk;
      sclk2_r <= sclk1_r;
    end
  end
  assign sclk_s = sclk2_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
      load_d_r <= 1'b0;
      slip_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      load_d_r <= load_s;
      slip_d_r <= slip_s;
    end
  end

  logic sclk_rise;
  logic load_rise;
  logic slip_rise;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign load_rise = load_s & ~load_d_r;
  assign slip_rise = slip_s & ~slip_d_r;

  // ----------------------------------------------------------------------
  // serial shift register
  // ----------------------------------------------------------------------
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;

  // shifting left drops the oldest bit, so extra leading bits fall off
  assign shift_nxt = {shift_r[22:0], sdat_s};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r <= dfs_pkg::WORD_RST;
    end else if (sclk_rise && !load_s) begin
      shift_r <= shift_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // setting latches
  // ----------------------------------------------------------------------
  logic [23:0] word_a_r;
  logic [23:0] word_b_r;
  logic [23:0] word_c_r;
  logic [23:0] word_d_r;
  logic test_mode_r;
  logic [2:0] load_addr;
  assign load_addr = shift_r[dfs_pkg::ADDR_HI:dfs_pkg::ADDR_LO];

  // no standby term: contents change only on a load or a power-up reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_a_r <= dfs_pkg::WORD_RST;
      word_b_r <= dfs_pkg::WORD_RST;
      word_c_r <= dfs_pkg::WORD_RST;
      word_d_r <= dfs_pkg::WORD_RST;
    end else if (load_rise) begin
      unique case (load_addr)
        dfs_pkg::LATCH_A: word_a_r <= shift_r;
        dfs_pkg::LATCH_B: word_b_r <= shift_r;
        dfs_pkg::LATCH_C: word_c_r <= shift_r;
        dfs_pkg::LATCH_D: word_d_r <= shift_r;
        default: ;
      endcase
    end
  end

  // test latch: any nonzero payload arms it, an all-zero one clears it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      test_mode_r <= 1'b0;
    end else if (load_rise && load_addr == dfs_pkg::LATCH_E) begin
      test_mode_r <= |shift_r[20:0];
    end
  end

  // ----------------------------------------------------------------------
  // frequency word
  // ----------------------------------------------------------------------
  logic [21:0] prof_word;
  logic [7:0] dev;
  logic fsk_on;
  logic [23:0] dev_ofs;
  logic [23:0] freq_r;
  logic [23:0] freq_nxt;

  assign prof_word = prof_s ? word_b_r[21:0] : word_a_r[21:0];
  assign dev = word_c_r[dfs_pkg::DEV_LO +: dfs_pkg::DEV_W];
  assign fsk_on = ~word_c_r[dfs_pkg::MOD_SEL_BIT];
  assign dev_ofs = {14'h0, dev, 2'h0};
  // the host keeps tx_mod low in receive; no receive gating here
  assign freq_nxt = {2'h0, prof_word}
                  + ((fsk_on && txm_s) ? dev_ofs : 24'h000000);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      freq_r <= 24'h000000;
    end else begin
      freq_r <= freq_nxt;
    end
  end

  // accumulator is never cleared on a frequency change
  dfs_nco u_nco (
    .clk(clk),
    .reset(reset),
    .freq_word(freq_r),
    .phase(),
    .dac_out(dac_out)
  );

  // ----------------------------------------------------------------------
  // pll controls
  // ----------------------------------------------------------------------
  function automatic logic [9:0] dfs_ratio(input logic sel);
    return sel ? dfs_pkg::DIV_RATIO_HI : dfs_pkg::DIV_RATIO_LO;
  endfunction : dfs_ratio

  logic pump_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pump_r <= 1'b0;
    end else begin
      pump_r <= slip_rise & ~lock_s;
    end
  end

  assign div_ratio = dfs_ratio(word_c_r[dfs_pkg::DIV_SEL_BIT]);
  assign acq_gain =
    word_c_r[dfs_pkg::ACQ_GAIN_HI:dfs_pkg::ACQ_GAIN_LO];
  assign acquisition_pump_out = pump_r;
  assign osc_enable = word_d_r[dfs_pkg::OSC_EN_BIT];
  assign test_mode = test_mode_r;

  // ----------------------------------------------------------------------
  // control register and slicer
  // ----------------------------------------------------------------------
  logic hold_r;
  logic signed [7:0] thr_r;
  logic signed [8:0] err;
  logic signed [8:0] step;
  logic rx_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_r <= 1'b0;
    end else if (reg_we && reg_addr == dfs_pkg::OFS_CTRL) begin
      hold_r <= reg_wdata[dfs_pkg::CTRL_HOLD_BIT];
    end
  end

  // leaky integrator: slow on purpose, the training sequence averages out
  assign err = 9'(demod_sample) - 9'(thr_r);
  assign step = err >>> dfs_pkg::LEAK_SHIFT;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thr_r <= 8'sh00;
    end else if (!hold_r) begin
      thr_r <= 8'(9'(thr_r) + step);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_r <= 1'b0;
    end else begin
      rx_r <= (demod_sample > thr_r);
    end
  end

  assign threshold_hold_cap = thr_r;
  assign rx_data = rx_r;

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_re) begin
      unique case (reg_addr)
        dfs_pkg::OFS_CTRL: rdata_nxt = {31'h0, hold_r};
        dfs_pkg::OFS_WORD_A: rdata_nxt = {8'h00, word_a_r};
        dfs_pkg::OFS_WORD_B: rdata_nxt = {8'h00, word_b_r};
        dfs_pkg::OFS_WORD_C: rdata_nxt = {8'h00, word_c_r};
        dfs_pkg::OFS_WORD_D: rdata_nxt = {8'h00, word_d_r};
        dfs_pkg::OFS_STATUS: rdata_nxt = {27'h0, rx_r, test_mode_r,
                                          txm_s, prof_s, lock_s};
        dfs_pkg::OFS_FREQ: rdata_nxt = {8'h00, freq_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule : dfs_ctrl

/* File: dfs_pkg.sv */
/*
 * Shared constants of the synthesizer control core: serial word layout,
 * latch addresses, register port offsets, widths and reset values.
 * Assumes nothing of its surroundings; used by dfs_ctrl and dfs_nco.
 */
package dfs_pkg;
  // ----------------------------------------------------------------------
  // serial control word
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int ACC_W = 24;
  localparam int PROF_W = 22;
  localparam int DEV_W = 8;
  localparam int DEV_SHIFT = 2;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 21;
  localparam logic [2:0] LATCH_A = 3'h0;
  localparam logic [2:0] LATCH_B = 3'h1;
  localparam logic [2:0] LATCH_C = 3'h2;
  localparam logic [2:0] LATCH_D = 3'h3;
  localparam logic [2:0] LATCH_E = 3'h7;
  // c-word fields
  localparam int MOD_SEL_BIT = 16;
  localparam int ACQ_GAIN_HI = 15;
  localparam int ACQ_GAIN_LO = 13;
  localparam int DIV_SEL_BIT = 12;
  localparam int DEV_LO = 0;
  // d-word fields
  localparam int OSC_EN_BIT = 0;
  localparam logic [23:0] WORD_RST = 24'h000000;
  // ----------------------------------------------------------------------
  // prescaler ratios
  // ----------------------------------------------------------------------
  localparam logic [9:0] DIV_RATIO_LO = 10'h100;
  localparam logic [9:0] DIV_RATIO_HI = 10'h200;
  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  localparam int RA_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WORD_A = 8'h04;
  localparam logic [7:0] OFS_WORD_B = 8'h08;
  localparam logic [7:0] OFS_WORD_C = 8'h0C;
  localparam logic [7:0] OFS_WORD_D = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FREQ = 8'h18;
  localparam int CTRL_HOLD_BIT = 0;
  // ----------------------------------------------------------------------
  // slicer and dac
  // ----------------------------------------------------------------------
  localparam int SAMP_W = 8;
  localparam int LEAK_SHIFT = 4;
  localparam int DAC_W = 10;
  localparam logic [9:0] DAC_MID = 10'h200;
endpackage : dfs_pkg

/* File: dfs_nco.sv */
/*
 * Phase accumulator and quarter-wave sine lookup feeding the dac.
 * Assumes a frequency word that is already registered on clk.
 */
`timescale 1ns/1ps
module dfs_nco (
  input wire logic clk,
  input wire logic reset,
  input wire logic [23:0] freq_word,
  output logic [23:0] phase,
  output logic [9:0] dac_out
);
  // ----------------------------------------------------------------------
  // sine table
  // ----------------------------------------------------------------------
  function automatic logic [8:0] dfs_quarter_sin(input logic [3:0] idx);
    logic [8:0] v;
    v = 9'h000;
    unique case (idx)
      4'h0: v = 9'h019;
      4'h1: v = 9'h04B;
      4'h2: v = 9'h07C;
      4'h3: v = 9'h0AC;
      4'h4: v = 9'h0DA;
      4'h5: v = 9'h107;
      4'h6: v = 9'h130;
      4'h7: v = 9'h157;
      4'h8: v = 9'h17B;
      4'h9: v = 9'h19A;
      4'hA: v = 9'h1B6;
      4'hB: v = 9'h1CE;
      4'hC: v = 9'h1E1;
      4'hD: v = 9'h1F0;
      4'hE: v = 9'h1F9;
      4'hF: v = 9'h1FE;
    endcase
    return v;
  endfunction : dfs_quarter_sin

  logic [23:0] phase_r;
  logic [23:0] phase_nxt;
  logic [3:0] idx;
  logic [8:0] amp;
  logic [9:0] dac_r;

  // ----------------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------------
  // unsigned add, carry dropped: natural wrap at full scale
  assign phase_nxt = phase_r + freq_word;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r <= 24'h000000;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------------
  // bits 22 and 21 pick the quadrant, bits 20 to 17 the table entry
  assign idx = phase_r[21] ? ~phase_r[20:17] : phase_r[20:17];
  assign amp = dfs_quarter_sin(idx);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dac_r <= dfs_pkg::DAC_MID;
    end else if (phase_r[22]) begin
      dac_r <= dfs_pkg::DAC_MID - {1'b0, amp};
    end else begin
      dac_r <= dfs_pkg::DAC_MID + {1'b0, amp};
    end
  end

  assign phase = phase_r;
  assign dac_out = dac_r;
endmodule : dfs_nco

/* File: dfs_host.sv */
/*
 * Host model: bit-bangs the three-wire serial port of dfs_ctrl.
 * Assumes the device samples these pins with its own clock.
 */
`timescale 1ns/1ps
module dfs_host (
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end

  // one bit per 48 ns, data settles while the clock is low
  task automatic shift_bit(input logic b);
    ser_data = b;
    #12 ser_clk = 1'b1;
    #24 ser_clk = 1'b0;
    #12;
  endtask : shift_bit

  // msb first; clock and data parked low under the load pulse
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      shift_bit(w[i]);
    end
    ser_data = 1'b0;
    #24 ser_load = 1'b1;
    #24 ser_load = 1'b0;
    #48;
  endtask : send_word
endmodule : dfs_host

/* File: dfs_ctrl_chk.sv */
/*
 * Port-level assertions for dfs_ctrl.
 * Assumes a single clock domain and the offsets of dfs_pkg.
 */
`timescale 1ns/1ps
module dfs_ctrl_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic phase_slip,
  input wire logic pll_locked,
  input wire logic ser_load,
  input wire logic signed [7:0] demod_sample,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic [9:0] div_ratio,
  input wire logic [2:0] acq_gain,
  input wire logic acquisition_pump_out,
  input wire logic osc_enable,
  input wire logic test_mode,
  input wire logic signed [7:0] threshold_hold_cap,
  input wire logic rx_data
);
  // shadow of the slicer hold bit, the mode is not visible at the pins
  logic hold_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_r <= 1'b0;
    end else if (reg_we && reg_addr == dfs_pkg::OFS_CTRL) begin
      hold_r <= reg_wdata[dfs_pkg::CTRL_HOLD_BIT];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_div_two_ratios: assert property (
    div_ratio == dfs_pkg::DIV_RATIO_LO || div_ratio == dfs_pkg::DIV_RATIO_HI)
    else $error("divider ratio neither 256 nor 512");
  a_pump_off_locked: assert property (
    pll_locked [*6] |-> !acquisition_pump_out)
    else $error("acquisition pump pulsed while locked");
  a_pump_one_cycle: assert property (
    acquisition_pump_out |=> !acquisition_pump_out)
    else $error("acquisition pump pulse longer than one cycle");
  a_pump_from_slip: assert property (
    acquisition_pump_out |-> $past(phase_slip, 2) || $past(phase_slip, 3)
      || $past(phase_slip, 4) || $past(phase_slip, 5))
    else $error("acquisition pump pulsed without a slip");
  a_static_settings: assert property (
    !ser_load [*8] |-> $stable({acq_gain, div_ratio, osc_enable, test_mode}))
    else $error("settings changed without a load");
  a_hold_keeps_thr: assert property (
    hold_r && $past(hold_r) |-> $stable(threshold_hold_cap))
    else $error("threshold moved in hold mode");
  a_learn_tracks: assert property (
    !hold_r && int'(demod_sample) - int'(threshold_hold_cap) >= 16
      |=> threshold_hold_cap > $past(threshold_hold_cap))
    else $error("threshold not integrating in learning mode");
  a_rx_slices: assert property (
    !$past(reset) |->
      rx_data == ($past(demod_sample) > $past(threshold_hold_cap)))
    else $error("received data does not follow the threshold");
endmodule : dfs_ctrl_chk

bind dfs_ctrl dfs_ctrl_chk u_dfs_ctrl_chk (
  .clk(clk), .reset(reset), .phase_slip(phase_slip),
  .pll_locked(pll_locked), .ser_load(ser_load),
  .demod_sample(demod_sample), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .div_ratio(div_ratio),
  .acq_gain(acq_gain), .acquisition_pump_out(acquisition_pump_out),
  .osc_enable(osc_enable), .test_mode(test_mode),
  .threshold_hold_cap(threshold_hold_cap), .rx_data(rx_data)
);

/* File: dfs_ctrl_tb.sv */
/*
 * Self-checking bench for dfs_ctrl with the serial host model.
 * Assumes dfs_pkg, dfs_host and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module dfs_ctrl_tb;
  logic clk = 1'b0;
  logic reset;
  logic profile_sel, tx_mod, pll_locked;
  logic phase_slip, reg_we, reg_re;
  logic signed [7:0] demod_sample;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [9:0] dac_out, div_ratio;
  logic [2:0] acq_gain;
  logic acquisition_pump_out, osc_enable, test_mode, rx_data;
  logic ser_clk, ser_data, ser_load;
  logic signed [7:0] threshold_hold_cap;
  int miscompares = 0;
  int checks_done = 0;

  dfs_host u_dfs_host (.ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load(ser_load));
  dfs_ctrl u_dfs_ctrl (.clk(clk), .reset(reset), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_load(ser_load), .profile_sel(profile_sel),
    .tx_mod(tx_mod), .pll_locked(pll_locked), .phase_slip(phase_slip),
    .demod_sample(demod_sample), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .dac_out(dac_out), .div_ratio(div_ratio),
    .acq_gain(acq_gain), .acquisition_pump_out(acquisition_pump_out),
    .osc_enable(osc_enable), .test_mode(test_mode),
    .threshold_hold_cap(threshold_hold_cap), .rx_data(rx_data));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd

  // pins pass a synchroniser, so give them time before reading back
  task automatic pins(input logic p, input logic t);
    @(posedge clk);
    profile_sel <= p;
    tx_mod <= t;
    repeat (8) @(posedge clk);
    rd(dfs_pkg::OFS_FREQ);
  endtask : pins

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // zero frequency word: phase parked at zero, dac on the first table step
  task automatic t_reset;
    logic [9:0] d0;
    repeat (16) @(posedge clk);
    d0 = dac_out;
    repeat (4) @(posedge clk);
    chk(32'(dac_out), 32'(d0));
    chk(32'(dac_out - dfs_pkg::DAC_MID < 10'h040), 32'h1);
    chk(32'(div_ratio), 32'(dfs_pkg::DIV_RATIO_LO));
    wr(dfs_pkg::OFS_WORD_A, 32'h00FFFFFF);
    rd(dfs_pkg::OFS_WORD_A);
    chk(rdv, 32'h0);
    rd(8'h1C);
    chk(rdv, 32'h0);
  endtask : t_reset

  task automatic t_serial;
    logic [23:0] w;
    w = {3'h2, 4'h0, 1'b1, 3'h5, 1'b1, 4'h0, 8'h11};
    u_dfs_host.shift_bit(1'b1);
    u_dfs_host.shift_bit(1'b1);
    u_dfs_host.send_word(w);
    chk(32'(acq_gain), 32'h5);
    chk(32'(div_ratio), 32'(dfs_pkg::DIV_RATIO_HI));
    rd(dfs_pkg::OFS_WORD_C);
    chk(rdv, {8'h0, w});
    u_dfs_host.send_word({3'h2, 4'h0, 1'b0, 3'h2, 1'b0, 4'h0, 8'h11});
    chk(32'(acq_gain), 32'h2);
    chk(32'(div_ratio), 32'(dfs_pkg::DIV_RATIO_LO));
  endtask : t_serial

  task automatic t_freq;
    logic hi, lo;
    u_dfs_host.send_word(24'h1ABCDE);
    u_dfs_host.send_word(24'h3F0F0F);
    pins(1'b0, 1'b0);
    chk(rdv, 32'h001ABCDE);
    hi = 1'b0;
    lo = 1'b0;
    repeat (32) begin
      @(negedge clk);
      hi = hi | (dac_out > dfs_pkg::DAC_MID);
      lo = lo | (dac_out < dfs_pkg::DAC_MID);
    end
    chk(32'({hi, lo}), 32'h3);
    pins(1'b0, 1'b1);
    chk(rdv, 32'h001ABD22);
    // bit 21 of profile one doubles as an address bit, so it is masked
    pins(1'b1, 1'b0);
    chk(rdv & 32'hFFDFFFFF, 32'h001F0F0F);
    u_dfs_host.send_word({3'h2, 4'h0, 1'b1, 3'h2, 1'b0, 4'h0, 8'h11});
    pins(1'b0, 1'b1);
    chk(rdv, 32'h001ABCDE);
    pins(1'b0, 1'b0); // receive with tx data low
  endtask : t_freq

  task automatic t_slicer;
    @(posedge clk);
    demod_sample <= 8'sh40;
    repeat (200) @(posedge clk);
    chk(32'(threshold_hold_cap), 32'h31);
    wr(dfs_pkg::OFS_CTRL, 32'h1); // hold after training
    demod_sample <= -8'sh14;
    repeat (40) @(posedge clk);
    chk(32'(rx_data), 32'h0);
    chk(32'(threshold_hold_cap), 32'h31);
    demod_sample <= 8'sh64;
    repeat (3) @(posedge clk);
    chk(32'(rx_data), 32'h1);
    wr(dfs_pkg::OFS_CTRL, 32'h0);
  endtask : t_slicer

  task automatic t_pump;
    logic seen;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pll_locked <= k[0];
      repeat (6) @(posedge clk);
      phase_slip <= 1'b1;
      seen = 1'b0;
      repeat (10) begin
        @(negedge clk);
        seen = seen | acquisition_pump_out;
      end
      @(posedge clk);
      phase_slip <= 1'b0;
      chk(32'(seen), 32'(!k[0]));
    end
  endtask : t_pump

  task automatic t_latch;
    u_dfs_host.send_word(24'hE00005);
    chk(32'(test_mode), 32'h1);
    u_dfs_host.send_word(24'hE00000);
    chk(32'(test_mode), 32'h0);
    u_dfs_host.send_word(24'h600001);
    chk(32'(osc_enable), 32'h1);
    u_dfs_host.send_word(24'h600000); // external oscillator
    chk(32'(osc_enable), 32'h0);
    rd(dfs_pkg::OFS_WORD_C);
    chk(rdv, 32'h00414011);
  endtask : t_latch

  initial begin
    reset <= 1'b1;
    profile_sel <= 1'b0;
    tx_mod <= 1'b0;
    pll_locked <= 1'b0;
    phase_slip <= 1'b0;
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    demod_sample <= 8'sh00;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h00000000;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_serial();
    t_freq();
    t_slicer();
    t_pump();
    t_latch();
    end_sim();
  end

  // the whole run needs well under 50 us
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule : dfs_ctrl_tb
